// ===== rtl/ring_trip_regs.svh
// Purpose: Offsets, field positions and timing counts of the ring offset and trip block.
// Assumes: Byte-wide direct register port, 16-bit indirect registers.
// Notes: Definitions only.
`ifndef RING_TRIP_REGS_SVH
`define RING_TRIP_REGS_SVH

// Direct register offsets
`define ADDR_IRQ_PEND 8'h13
`define ADDR_IRQ_MASK 8'h16
`define ADDR_IND_DLO 8'h1c
`define ADDR_IND_DHI 8'h1d
`define ADDR_IND_WRITE 8'h1e
`define ADDR_IND_READ 8'h1f
`define ADDR_RING_CFG 8'h22
`define ADDR_LINEFEED 8'h40
`define ADDR_LINE_STAT 8'h44
`define ADDR_TRIP_DEB 8'h46
`define ADDR_HIGH_BAT 8'h4a
`define ADDR_LOOP_CUR 8'h4f
`define ADDR_CUR_LIM 8'h6c

// Indirect register indexes
`define IND_RING_OFFSET 8'h13
`define IND_TRIP_THR 8'h1d
`define IND_TRIP_COEF 8'h24
`define IND_HEADROOM 8'h28

// Field positions and codes
`define RING_CFG_OFFSET_EN_BIT 1
`define CUR_LIM_BOOST_BIT 7
`define IRQ_TRIP_BIT 0
`define STAT_TRIP_BIT 0
`define LINE_RINGING 3'h4
`define TRIP_THR_HI 13
`define TRIP_THR_LO 8
`define TRIP_COEF_HI 12
`define LPF_SHIFT 13

// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// Current limit boost after ringing
`define CLK_PERIOD_NS 8
`define BOOST_TIME_NS 100000
`define BOOST_CYCLES (`BOOST_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== rtl/ring_trip_pkg.sv
// Purpose: Types shared by the ring offset and trip block.
// Assumes: Nothing beyond the register header.
// Notes: Widths follow the register map.
package ring_trip_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [15:0] wave_word_t;
  typedef logic [6:0] deb_count_t;
  typedef logic [5:0] cm_level_t;
endpackage : ring_trip_pkg

// ===== rtl/trip_debouncer.sv
// Purpose: Debounce the ring trip comparator in loop current sample periods.
// Assumes: sample_en_in pulses once per processed sample.
// Notes: Interval 0 lets the first opposite sample through.
`timescale 1ns/10ps
`include "ring_trip_regs.svh"
module trip_debouncer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sample_en_in,
  input wire logic level_in,
  input wire ring_trip_pkg::deb_count_t interval_in,
  output logic state_out
);
  import ring_trip_pkg::*;

  deb_count_t cnt_q;
  deb_count_t cnt_d;
  logic state_d;
  wire differs = level_in != state_out;
  wire [7:0] cnt_inc = {1'b0, cnt_q} + 8'h01;
  wire reached = cnt_inc >= {1'b0, interval_in};

  // Flip only after a full interval of opposite samples
  assign state_d = (sample_en_in && differs && reached) ? ~state_out : state_out;
  // Any agreeing sample restarts the count
  assign cnt_d = !sample_en_in ? cnt_q : (!differs || reached) ? 7'h00 : cnt_inc[6:0];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 7'h00;
      state_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      state_out <= state_d;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_debounce_restart: assert property (
    sample_en_in && !differs |=> cnt_q == 7'h00 && $stable(state_out))
    else $error("Debounce count not restarted");
  a_debounce_flip: assert property (
    $changed(state_out) |-> $past(sample_en_in) && $past(differs) && $past(reached))
    else $error("Debouncer changed state early");
endmodule : trip_debouncer

// ===== rtl/ring_offset_trip_detector.sv
// Purpose: Ringing dc offset, ringing common mode, current limit boost and ring trip detection.
// Assumes: Loop current samples arrive with a one-cycle valid strobe at the processing rate.
// Notes: Indirect registers are reached only through the access window at 0x1c..0x1f.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "ring_trip_regs.svh"

// Notes on behaviour
// - Offset enable adds the programmed offset to the ringing wave, else none.
// - Ringing common mode is half of high battery minus headroom, automatically.
// - Headroom is a 4-bit indirect field, 1.5 V per step.
// - Boost enable raises the current limit briefly when leaving ringing.
// - Trip detection uses loop current samples, also readable by software.
// - Samples are processed only while the line state is ringing.
// - Samples pass a low-pass filter with a 13-bit indirect coefficient.
// - Filter output is compared to a 6-bit threshold, feeding the debouncer.
// - Debouncer flips only after a full interval of opposite comparator state.
// - A satisfied interval sets or clears the ring trip status bit, following the comparator.
// - A trip raises the pending interrupt only when its enable bit is set.
// - Indirect registers are reached only through direct addresses 28 to 31.
// - Line state code 100b selects ringing, qualifying the trip detector.
module ring_offset_trip_detector #(
  parameter int unsigned BOOST_CYCLES = `BOOST_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire ring_trip_pkg::reg_byte_t reg_addr_in,
  input wire ring_trip_pkg::reg_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output ring_trip_pkg::reg_byte_t reg_rdata_out,
  input wire ring_trip_pkg::reg_byte_t loop_current_sample_in,
  input wire logic sample_valid_in,
  input wire ring_trip_pkg::wave_word_t ring_wave_in,
  output ring_trip_pkg::wave_word_t ring_wave_out,
  output ring_trip_pkg::cm_level_t ringing_common_mode_out,
  output logic current_limit_boost_out,
  output logic irq_out
);
  import ring_trip_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg_byte_t mask_q, ring_cfg_q, clim_q, lcs_q, ind_dlo_q, ind_dhi_q, ind_addr_q;
  reg_byte_t rdata_q;
  logic trip_pend_q;
  logic [2:0] line_state_q;
  deb_count_t deb_q;
  logic [5:0] hbat_q;
  wave_word_t ring_offset_level_q, thr_q, coef_q, ringing_headroom_q, filt_q, wave_q;
  cm_level_t cm_q;
  logic [31:0] boost_cnt_q;
  logic boost_q, irq_q, trip_prev_q;
  logic trip_state;

  ////////////////////////////////////////////////////////////////////////////
  // Direct decode
  wire wr_pend = reg_wr_in && reg_addr_in == `ADDR_IRQ_PEND;
  wire wr_mask = reg_wr_in && reg_addr_in == `ADDR_IRQ_MASK;
  wire wr_dlo = reg_wr_in && reg_addr_in == `ADDR_IND_DLO;
  wire wr_dhi = reg_wr_in && reg_addr_in == `ADDR_IND_DHI;
  wire wr_iwr = reg_wr_in && reg_addr_in == `ADDR_IND_WRITE;
  wire wr_ird = reg_wr_in && reg_addr_in == `ADDR_IND_READ;
  wire wr_cfg = reg_wr_in && reg_addr_in == `ADDR_RING_CFG;
  wire wr_lf = reg_wr_in && reg_addr_in == `ADDR_LINEFEED;
  wire wr_deb = reg_wr_in && reg_addr_in == `ADDR_TRIP_DEB;
  wire wr_hbat = reg_wr_in && reg_addr_in == `ADDR_HIGH_BAT;
  wire wr_clim = reg_wr_in && reg_addr_in == `ADDR_CUR_LIM;

  // Indirect access: address register write moves the data pair in or out
  wire [15:0] ind_wdata = {ind_dhi_q, ind_dlo_q};
  wire ind_wr_off = wr_iwr && reg_wdata_in == `IND_RING_OFFSET;
  wire ind_wr_thr = wr_iwr && reg_wdata_in == `IND_TRIP_THR;
  wire ind_wr_coef = wr_iwr && reg_wdata_in == `IND_TRIP_COEF;
  wire ind_wr_ringing_headroom = wr_iwr && reg_wdata_in == `IND_HEADROOM;
  wire [15:0] ind_rd_word =
    (reg_wdata_in == `IND_RING_OFFSET) ? ring_offset_level_q :
    (reg_wdata_in == `IND_TRIP_THR) ? thr_q :
    (reg_wdata_in == `IND_TRIP_COEF) ? coef_q :
    (reg_wdata_in == `IND_HEADROOM) ? ringing_headroom_q : 16'h0000;
  wire [7:0] dlo_d = wr_ird ? ind_rd_word[7:0] : wr_dlo ? reg_wdata_in : ind_dlo_q;
  wire [7:0] dhi_d = wr_ird ? ind_rd_word[15:8] : wr_dhi ? reg_wdata_in : ind_dhi_q;

  ////////////////////////////////////////////////////////////////////////////
  // Offset and common mode
  wire offset_en = ring_cfg_q[`RING_CFG_OFFSET_EN_BIT];
  wire [16:0] wave_sum = {ring_wave_in[15], ring_wave_in} +
    (offset_en ? {ring_offset_level_q[15], ring_offset_level_q} : 17'h00000);
  // Saturate rather than wrap, so a large offset cannot flip the wave polarity
  wire [15:0] wave_d = (wave_sum[16] == wave_sum[15]) ? wave_sum[15:0] :
    wave_sum[16] ? 16'h8000 : 16'h7fff;
  // Both settings are in 1.5 V steps, so the difference read in 0.75 V steps is half of it
  wire [5:0] headroom = {2'b00, ringing_headroom_q[3:0]};
  wire [5:0] cm_d = (hbat_q >= headroom) ? hbat_q - headroom : 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Current limit boost on leaving ringing
  wire ringing = line_state_q == `LINE_RINGING;
  wire leave_ring = wr_lf && ringing && reg_wdata_in[2:0] != `LINE_RINGING;
  wire boost_start = leave_ring && clim_q[`CUR_LIM_BOOST_BIT];
  wire [31:0] boost_cnt_d = boost_start ? BOOST_CYCLES :
    (boost_cnt_q != 32'h0) ? boost_cnt_q - 32'h1 : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Ring trip path
  wire take_sample = sample_valid_in && ringing;
  wire signed [16:0] lpf_diff = $signed({1'b0, loop_current_sample_in, 8'h00}) - $signed({1'b0, filt_q});
  wire signed [30:0] lpf_prod = lpf_diff * $signed({1'b0, coef_q[`TRIP_COEF_HI:0]});
  wire signed [30:0] lpf_step = lpf_prod >>> `LPF_SHIFT;
  // Coefficient below one keeps the filter inside the sample range
  wire [15:0] filt_d = take_sample ? filt_q + lpf_step[15:0] : filt_q;
  wire [15:0] thr_level = {2'b00, thr_q[`TRIP_THR_HI:`TRIP_THR_LO], 8'h00};
  wire trip_cmp = filt_q > thr_level;

  trip_debouncer u_debouncer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sample_en_in(take_sample),
    .level_in(trip_cmp),
    .interval_in(deb_q),
    .state_out(trip_state)
  );

  wire trip_event = trip_state && !trip_prev_q;
  wire trip_en = mask_q[`IRQ_TRIP_BIT];
  // A trip in the same cycle as a clear write still lands
  wire pend_clr = wr_pend && reg_wdata_in[`IRQ_TRIP_BIT];
  wire pend_d = (trip_event && trip_en) || (trip_pend_q && !pend_clr);
  wire irq_d = pend_d && trip_en;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux =
    (reg_addr_in == `ADDR_IRQ_PEND) ? {7'h00, trip_pend_q} :
    (reg_addr_in == `ADDR_IRQ_MASK) ? mask_q :
    (reg_addr_in == `ADDR_IND_DLO) ? ind_dlo_q :
    (reg_addr_in == `ADDR_IND_DHI) ? ind_dhi_q :
    (reg_addr_in == `ADDR_IND_WRITE) ? ind_addr_q :
    (reg_addr_in == `ADDR_RING_CFG) ? ring_cfg_q :
    (reg_addr_in == `ADDR_LINEFEED) ? {1'b0, line_state_q, 1'b0, line_state_q} :
    (reg_addr_in == `ADDR_LINE_STAT) ? {7'h00, trip_state} :
    (reg_addr_in == `ADDR_TRIP_DEB) ? {1'b0, deb_q} :
    (reg_addr_in == `ADDR_HIGH_BAT) ? {2'b00, hbat_q} :
    (reg_addr_in == `ADDR_LOOP_CUR) ? lcs_q :
    (reg_addr_in == `ADDR_CUR_LIM) ? clim_q : 8'h00;
  wire [7:0] rdata_d = reg_rd_in ? rd_mux : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_q <= `RST_BYTE;
      ring_cfg_q <= `RST_BYTE;
      clim_q <= `RST_BYTE;
      ind_dlo_q <= `RST_BYTE;
      ind_dhi_q <= `RST_BYTE;
      ind_addr_q <= `RST_BYTE;
      line_state_q <= 3'h0;
      deb_q <= 7'h00;
      hbat_q <= 6'h00;
    end else begin
      if (wr_mask) mask_q <= reg_wdata_in;
      if (wr_cfg) ring_cfg_q <= reg_wdata_in;
      if (wr_clim) clim_q <= reg_wdata_in;
      if (wr_iwr || wr_ird) ind_addr_q <= reg_wdata_in;
      if (wr_lf) line_state_q <= reg_wdata_in[2:0];
      if (wr_deb) deb_q <= reg_wdata_in[6:0];
      if (wr_hbat) hbat_q <= reg_wdata_in[5:0];
      ind_dlo_q <= dlo_d;
      ind_dhi_q <= dhi_d;
    end
  end

  // Indirect registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ring_offset_level_q <= `RST_WORD;
      thr_q <= `RST_WORD;
      coef_q <= `RST_WORD;
      ringing_headroom_q <= `RST_WORD;
    end else begin
      if (ind_wr_off) ring_offset_level_q <= ind_wdata;
      if (ind_wr_thr) thr_q <= ind_wdata;
      if (ind_wr_coef) coef_q <= ind_wdata;
      if (ind_wr_ringing_headroom) ringing_headroom_q <= ind_wdata;
    end
  end

  // Datapath and outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lcs_q <= `RST_BYTE;
      filt_q <= `RST_WORD;
      wave_q <= `RST_WORD;
      cm_q <= 6'h00;
      boost_cnt_q <= 32'h0;
      boost_q <= 1'b0;
      trip_prev_q <= 1'b0;
      trip_pend_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= `RST_BYTE;
    end else begin
      if (sample_valid_in) lcs_q <= loop_current_sample_in;
      filt_q <= filt_d;
      wave_q <= wave_d;
      cm_q <= cm_d;
      boost_cnt_q <= boost_cnt_d;
      boost_q <= boost_cnt_d != 32'h0;
      trip_prev_q <= trip_state;
      trip_pend_q <= pend_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign ring_wave_out = wave_q;
  assign ringing_common_mode_out = cm_q;
  assign current_limit_boost_out = boost_q;
  assign irq_out = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_leave_ringing;
    boost_start;
  endsequence
  sequence s_boost_held;
    current_limit_boost_out [*2];
  endsequence

  a_offset_off: assert property (
    !offset_en |=> ring_wave_out == $past(ring_wave_in))
    else $error("Wave changed with offset disabled");
  a_cm_level: assert property (
    hbat_q >= headroom |=> ringing_common_mode_out == $past(hbat_q - headroom))
    else $error("Common mode level wrong");
  a_boost_start: assert property (
    s_leave_ringing |=> s_boost_held)
    else $error("Boost missing after leaving ringing");
  a_no_boost: assert property (
    !clim_q[`CUR_LIM_BOOST_BIT] && boost_cnt_q == 32'h0 |=> !current_limit_boost_out)
    else $error("Boost without enable");
  a_idle_hold: assert property (
    !ringing |=> $stable(filt_q))
    else $error("Filter moved outside ringing");
  a_trip_pend: assert property (
    trip_event && trip_en |=> trip_pend_q ##1 irq_out)
    else $error("Trip did not raise interrupt");
  a_pend_masked: assert property (
    !trip_pend_q && !(trip_event && trip_en) |=> !trip_pend_q)
    else $error("Pending set without enabled trip");
  a_pend_sticky: assert property (
    trip_pend_q && !pend_clr |=> trip_pend_q)
    else $error("Pending flag lost");
  a_loop_read: assert property (
    reg_rd_in && reg_addr_in == `ADDR_LOOP_CUR |=> reg_rdata_out == $past(lcs_q))
    else $error("Loop current read wrong");
  a_ind_write: assert property (
    ind_wr_off |=> ring_offset_level_q == $past(ind_wdata))
    else $error("Indirect offset write lost");
endmodule : ring_offset_trip_detector

// ===== verification/line_sample_model.sv
// Purpose: Far-side loop current source feeding sampled line current to the trip detector.
// Assumes: One valid pulse per sample, spacing set by gap_in.
// Notes: Between samples the data lines toggle so stale values are never trusted.
`timescale 1ns/10ps
module line_sample_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic [7:0] level_in,
  input wire logic [7:0] count_in,
  input wire logic [3:0] gap_in,
  output logic [7:0] sample_out,
  output logic valid_out,
  output logic busy_out
);
  logic [7:0] left_q;
  logic [3:0] wait_q;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left_q <= 8'h00;
      wait_q <= 4'h0;
      valid_out <= 1'b0;
      sample_out <= 8'h00;
    end else begin
      valid_out <= 1'b0;
      sample_out <= ~sample_out;
      if (go_in) begin
        left_q <= count_in;
        wait_q <= 4'h0;
      end else if (left_q != 8'h00) begin
        if (wait_q == 4'h0) begin
          valid_out <= 1'b1;
          sample_out <= level_in;
          left_q <= left_q - 8'h01;
          wait_q <= gap_in;
        end else begin
          wait_q <= wait_q - 4'h1;
        end
      end
    end
  end
  assign busy_out = (left_q != 8'h00) || valid_out;
endmodule : line_sample_model

// ===== verification/ring_offset_trip_detector_tb.sv
// Purpose: Self-checking bench for ring offset, common mode, boost and ring trip detection.
// Assumes: Boost window shortened to 8 cycles.
// Notes: Random stimulus from a fixed seed.
`timescale 1ns/10ps
`include "ring_trip_regs.svh"
module ring_offset_trip_detector_tb;
  import ring_trip_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr = 1'b0, rd = 1'b0, go = 1'b0, boost, irq, valid, busy;
  reg_byte_t addr = 8'h00, wdata = 8'h00, lvl = 8'h00, cnt = 8'h00, rdata, sample, rv;
  logic [3:0] gap = 4'h0;
  wave_word_t wave_in = 16'h0000, wave_out, w;
  cm_level_t cm;
  int error_cnt = 0, compares = 0, seed = 16, hb, hr, n;
  always #4 clk_in = ~clk_in;
  ring_offset_trip_detector #(.BOOST_CYCLES(8)) ring_offset_trip_detector_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .loop_current_sample_in(sample), .sample_valid_in(valid), .ring_wave_in(wave_in),
    .ring_wave_out(wave_out), .ringing_common_mode_out(cm), .current_limit_boost_out(boost), .irq_out(irq));
  line_sample_model line_sample_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go), .level_in(lvl),
    .count_in(cnt), .gap_in(gap), .sample_out(sample), .valid_out(valid), .busy_out(busy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr_reg(input reg_byte_t a, input reg_byte_t d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic chk_reg(input reg_byte_t a, input reg_byte_t exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #2;
    chk(rdata, exp);
  endtask : chk_reg
  // Indirect words go low byte, high byte, then index
  task automatic wr_ind(input reg_byte_t idx, input wave_word_t v);
    wr_reg(`ADDR_IND_DLO, v[7:0]);
    wr_reg(`ADDR_IND_DHI, v[15:8]);
    wr_reg(`ADDR_IND_WRITE, idx);
  endtask : wr_ind
  task automatic send(input reg_byte_t lv, input reg_byte_t k);
    int i;
    @(posedge clk_in);
    lvl <= lv;
    cnt <= k;
    gap <= 4'($random(seed) & 3);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    // Let the model load its count before busy is trusted
    @(posedge clk_in);
    for (i = 0; i < 100 && busy; i++) @(posedge clk_in);
    if (busy) begin
      error_cnt++;
      tally_and_finish();
    end
    repeat (4) @(posedge clk_in);
  endtask : send
  function automatic wave_word_t wave_exp(input wave_word_t x, input wave_word_t off, input logic en);
    logic signed [16:0] s;
    s = $signed({x[15], x}) + (en ? $signed({off[15], off}) : 17'sh00000);
    if (s > 17'sh07fff) return 16'h7fff;
    if (s < $signed(17'h18000)) return 16'h8000;
    return s[15:0];
  endfunction : wave_exp
  // Both settings are in 1.5 V steps, output in 0.75 V, so half the difference is the raw difference
  function automatic cm_level_t cm_exp(input int b, input int h);
    return (b > h) ? cm_level_t'(b - h) : 6'h00;
  endfunction : cm_exp
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk_reg(`ADDR_IRQ_MASK, 8'h00);
    wr_reg(`ADDR_RING_CFG, 8'ha4);
    chk_reg(`ADDR_RING_CFG, 8'ha4);
    wr_reg(8'h7e, 8'hff);
    chk_reg(8'h7e, 8'h00);
    $display("test registers done");
    wr_ind(`IND_RING_OFFSET, 16'h0100); // 0.75 V scaled by 2^15/96
    for (int i = 0; i < 10; i++) begin
      if (i == 8) wr_ind(`IND_RING_OFFSET, 16'h4000);
      wr_reg(`ADDR_RING_CFG, {6'h00, i[0] | (i >= 8), 1'b0});
      w = (i >= 8) ? 16'h6000 : 16'($random(seed) & 16'h3fff);
      wave_in <= w;
      repeat (2) @(posedge clk_in);
      #2;
      chk(wave_out, wave_exp(w, (i >= 8) ? 16'h4000 : 16'h0100, i[0] | (i >= 8)));
    end
    $display("test offset done");
    for (int i = 0; i < 6; i++) begin
      hb = (i == 0) ? 3 : ($random(seed) & 63);
      hr = (i == 0) ? 9 : ($random(seed) & 15);
      wr_reg(`ADDR_HIGH_BAT, 8'(hb));
      wr_ind(`IND_HEADROOM, 16'(hr));
      repeat (2) @(posedge clk_in);
      #2;
      chk(cm, cm_exp(hb, hr));
    end
    $display("test common mode done");
    for (int en = 0; en < 2; en++) begin
      wr_reg(`ADDR_CUR_LIM, {en[0], 7'h00});
      wr_reg(`ADDR_LINEFEED, 8'h04);
      chk_reg(`ADDR_LINEFEED, 8'h44);
      wr_reg(`ADDR_LINEFEED, 8'h01);
      n = 0;
      repeat (20) begin
        @(negedge clk_in);
        n += int'(boost === 1'b1);
      end
      chk(16'(n), en ? 16'h0008 : 16'h0000);
    end
    $display("test boost done");
    wr_ind(`IND_TRIP_COEF, 16'h1fff);
    wr_ind(`IND_TRIP_THR, 16'h0100);
    wr_reg(`ADDR_TRIP_DEB, 8'h03);
    wr_reg(`ADDR_IRQ_MASK, 8'h01);
    send(8'hff, 8'h06);
    chk_reg(`ADDR_LINE_STAT, 8'h00);
    chk_reg(`ADDR_LOOP_CUR, 8'hff);
    wr_reg(`ADDR_LINEFEED, 8'h04);
    send(8'hff, 8'h03);
    chk_reg(`ADDR_LINE_STAT, 8'h00);
    send(8'hff, 8'h01);
    chk_reg(`ADDR_LINE_STAT, 8'h01);
    chk_reg(`ADDR_IRQ_PEND, 8'h01);
    repeat (5) @(posedge clk_in);
    #2;
    chk(irq, 1'b1);
    wr_reg(`ADDR_IRQ_PEND, 8'h01);
    chk_reg(`ADDR_IRQ_PEND, 8'h00);
    chk(irq, 1'b0);
    send(8'h00, 8'h06);
    chk_reg(`ADDR_LINE_STAT, 8'h00);
    wr_reg(`ADDR_IRQ_MASK, 8'h00);
    send(8'hff, 8'h05);
    chk_reg(`ADDR_LINE_STAT, 8'h01);
    chk_reg(`ADDR_IRQ_PEND, 8'h00);
    chk(irq, 1'b0);
    $display("test ring trip done");
    tally_and_finish();
  end
  initial begin
    repeat (50000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule : ring_offset_trip_detector_tb
